// ### hdl/itpf_pkg.sv
// Constants shared by the image table pointer fetch block
`default_nettype none
package itpf_pkg;
	localparam logic [7:0] SPI_READ_CMD = 8'h03;
	localparam logic [5:0] CMD_BITS = 6'h20;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [15:0] TABLE_BYTES = 16'h0008;
	localparam logic [31:0] NULL_PTR = 32'h00000000;
	localparam logic [63:0] TABLE_RESET = 64'h0000000000000000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam int REPL_PTR_LSB = 0;
	localparam int EBIT_PTR_LSB = 32;
	typedef enum logic [1:0] {ITPF_SH_IDLE, ITPF_SH_CMD, ITPF_SH_DATA} itpf_shim_state_t;
	typedef enum logic [1:0] {ITPF_LD_INIT, ITPF_LD_TABLE, ITPF_LD_READY} itpf_load_state_t;
endpackage
`default_nettype wire

// ### hdl/itpf_table_fetch.sv
// Image table pointer fetch with its SPI mode 0 fetch shim
`default_nettype none
module itpf_table_fetch #(
	parameter bit INJECT_ENABLE = 1'b1,
	parameter bit HID_DIRECT_PINS = 1'b1,
	parameter bit CORRECT_BY_RELOAD = 1'b1,
	parameter bit CLASSIFY_ENABLE = 1'b1,
	parameter bit SIM_HOLD = 1'b0
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [31:0] tbladdr_in,
	input wire logic fetch_req_in,
	input wire logic [31:0] fetch_addr_in,
	input wire logic [15:0] fetch_count_in,
	output logic fetch_ready_out,
	output logic [7:0] fetch_data_out,
	output logic fetch_valid_out,
	output logic fetch_done_out,
	output logic status_initialization_out,
	output logic table_valid_out,
	output logic [31:0] repl_ptr_out,
	output logic [31:0] ebit_ptr_out,
	output logic repl_present_out,
	output logic ebit_present_out,
	output logic image_missing_out,
	input wire logic inject_strobe_in,
	input wire logic [39:0] inject_address_in,
	output logic inject_pins_present_out,
	output logic inject_strobe_out,
	output logic [39:0] inject_address_out,
	output logic external_c_out,
	output logic external_d_out,
	output logic external_s_n_out,
	input wire logic external_q_in
);
	// Pin interface is elaborated away unless both options select it
	localparam bit INJECT_PINS = INJECT_ENABLE && HID_DIRECT_PINS;

	function automatic logic ptr_present(input logic [31:0] ptr);
		ptr_present = (ptr != itpf_pkg::NULL_PTR);
	endfunction

	itpf_pkg::itpf_shim_state_t sh_state_q;
	itpf_pkg::itpf_load_state_t ld_state_q;
	logic ph_q;
	logic [5:0] bit_q;
	logic [15:0] cnt_q;
	logic [31:0] sr_q;
	logic [7:0] rx_q;
	logic sclk_q;
	logic cs_n_q;
	logic [7:0] byte_q;
	logic byte_valid_q;
	logic done_q;
	logic [63:0] table_q;
	logic table_valid_q;
	logic inj_strobe_q;
	logic [39:0] inj_addr_q;
	logic shim_req;
	logic [31:0] shim_addr;
	logic [15:0] shim_count;
	logic shim_idle;
	logic last_cmd_bit;
	logic last_data_bit;

	assign shim_idle = (sh_state_q == itpf_pkg::ITPF_SH_IDLE);
	assign last_cmd_bit = (bit_q == itpf_pkg::CMD_BITS - 6'h01);
	assign last_data_bit = (bit_q[2:0] == itpf_pkg::BYTE_LAST_BIT);

	// Table load owns the shim until the pointers are known
	always_comb begin
		shim_req = 1'b0;
		shim_addr = fetch_addr_in;
		shim_count = fetch_count_in;
		unique case (ld_state_q)
			itpf_pkg::ITPF_LD_INIT: begin
				shim_req = !SIM_HOLD;
				shim_addr = tbladdr_in;
				shim_count = itpf_pkg::TABLE_BYTES;
			end
			itpf_pkg::ITPF_LD_TABLE: begin
				shim_req = 1'b0;
			end
			itpf_pkg::ITPF_LD_READY: begin
				shim_req = fetch_req_in && shim_idle;
			end
		endcase
	end

	// Serial engine: command plus 24-bit address, then data bytes
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			sh_state_q <= itpf_pkg::ITPF_SH_IDLE;
			ph_q <= 1'b0;
			bit_q <= 6'h00;
			cnt_q <= 16'h0000;
			sr_q <= 32'h00000000;
			rx_q <= 8'h00;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			unique case (sh_state_q)
				itpf_pkg::ITPF_SH_IDLE: begin
					sclk_q <= 1'b0;
					ph_q <= 1'b0;
					bit_q <= 6'h00;
					// Zero-length requests are dropped without touching the bus
					if (shim_req && shim_count != 16'h0000) begin
						sh_state_q <= itpf_pkg::ITPF_SH_CMD;
						cs_n_q <= 1'b0;
						cnt_q <= shim_count;
						sr_q <= {itpf_pkg::SPI_READ_CMD, shim_addr[23:0]};
					end
				end
				itpf_pkg::ITPF_SH_CMD, itpf_pkg::ITPF_SH_DATA: begin
					ph_q <= ~ph_q;
					if (!ph_q) begin
						sclk_q <= 1'b1;
						// Rising edge is the sample point; the slave changed on the last fall
						rx_q <= {rx_q[6:0], external_q_in};
					end else begin
						sclk_q <= 1'b0;
						sr_q <= {sr_q[30:0], 1'b0};
						bit_q <= bit_q + 6'h01;
						if (sh_state_q == itpf_pkg::ITPF_SH_CMD && last_cmd_bit) begin
							sh_state_q <= itpf_pkg::ITPF_SH_DATA;
							bit_q <= 6'h00;
						end else if (sh_state_q == itpf_pkg::ITPF_SH_DATA && last_data_bit) begin
							bit_q <= 6'h00;
							cnt_q <= cnt_q - 16'h0001;
							// Sequential read continues the burst for contiguous images
							if (cnt_q == itpf_pkg::COUNT_ONE) begin
								sh_state_q <= itpf_pkg::ITPF_SH_IDLE;
								cs_n_q <= 1'b1;
							end
						end
					end
				end
				default: begin
					sh_state_q <= itpf_pkg::ITPF_SH_IDLE;
					cs_n_q <= 1'b1;
				end
			endcase
		end
	end

	// Returned bytes and end-of-request pulse
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			byte_q <= 8'h00;
			byte_valid_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			byte_valid_q <= 1'b0;
			done_q <= 1'b0;
			if (sh_state_q == itpf_pkg::ITPF_SH_DATA && ph_q && last_data_bit) begin
				byte_q <= rx_q;
				byte_valid_q <= 1'b1;
				done_q <= (cnt_q == itpf_pkg::COUNT_ONE);
			end
		end
	end

	// Pointer table load
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			ld_state_q <= itpf_pkg::ITPF_LD_INIT;
			table_q <= itpf_pkg::TABLE_RESET;
			table_valid_q <= 1'b0;
		end else begin
			unique case (ld_state_q)
				itpf_pkg::ITPF_LD_INIT: begin
					if (!SIM_HOLD && shim_idle) begin
						ld_state_q <= itpf_pkg::ITPF_LD_TABLE;
					end
				end
				itpf_pkg::ITPF_LD_TABLE: begin
					if (byte_valid_q) begin
						// Bytes arrive ascending, so shifting in from the top is little-endian
						table_q <= {byte_q, table_q[63:8]};
					end
					if (done_q) begin
						ld_state_q <= itpf_pkg::ITPF_LD_READY;
						table_valid_q <= 1'b1;
					end
				end
				itpf_pkg::ITPF_LD_READY: begin
					ld_state_q <= itpf_pkg::ITPF_LD_READY;
				end
				default: begin
					ld_state_q <= itpf_pkg::ITPF_LD_INIT;
				end
			endcase
		end
	end

	// Injection pass-through, registered; the registers load zero when the pins do not exist
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			inj_strobe_q <= 1'b0;
			inj_addr_q <= 40'h0000000000;
		end else begin
			inj_strobe_q <= INJECT_PINS && inject_strobe_in;
			inj_addr_q <= INJECT_PINS ? inject_address_in : 40'h0000000000;
		end
	end

	assign fetch_ready_out = (ld_state_q == itpf_pkg::ITPF_LD_READY) && shim_idle;
	assign fetch_data_out = byte_q;
	assign fetch_valid_out = byte_valid_q && table_valid_q;
	assign fetch_done_out = done_q && table_valid_q;
	assign status_initialization_out = !table_valid_q;
	assign table_valid_out = table_valid_q;
	assign repl_ptr_out = table_q[itpf_pkg::REPL_PTR_LSB +: 32];
	assign ebit_ptr_out = table_q[itpf_pkg::EBIT_PTR_LSB +: 32];
	assign repl_present_out = table_valid_q && ptr_present(repl_ptr_out);
	assign ebit_present_out = table_valid_q && ptr_present(ebit_ptr_out);
	// An enabled function whose image is absent cannot run
	assign image_missing_out = table_valid_q &&
		((CORRECT_BY_RELOAD && !ptr_present(repl_ptr_out)) ||
		(CLASSIFY_ENABLE && !ptr_present(ebit_ptr_out)));
	assign inject_pins_present_out = INJECT_PINS;
	assign inject_strobe_out = inj_strobe_q;
	assign inject_address_out = inj_addr_q;
	assign external_c_out = sclk_q;
	assign external_d_out = sr_q[31];
	assign external_s_n_out = cs_n_q;
endmodule
`default_nettype wire

// ### testbench/itpf_flash_model.sv
// SPI mode 0 flash model holding the image pointer table
`default_nettype none
module itpf_flash_model (
	input wire logic c_in,
	input wire logic s_n_in,
	input wire logic d_in,
	output logic q_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [31:0] sh;
	int n;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
		for (int i = 16; i < 32; i++) mem[i] = 8'h00;
		mem[16] = 8'h40;
		mem[19] = 8'h5a;
		q_out = 1'b0;
		n = 0;
	end
	always @(negedge s_n_in) n = 0;
	// Deselected output flips so a stale bit never looks valid
	always @(posedge s_n_in) q_out = ~q_out;
	// Command and address are held once taken, so data clocks cannot shift the start address away
	always @(posedge c_in) if (!s_n_in) begin
		if (n < 32) sh = {sh[30:0], d_in};
		n = n + 1;
	end
	always @(negedge c_in) if (!s_n_in && n >= 32) begin
		q_out = mem[8'(sh[7:0] + (n - 32) / 8)][7 - (n - 32) % 8];
	end else q_out = ~q_out;
endmodule
`default_nettype wire

// ### testbench/itpf_table_fetch_checker.sv
// Pin assertions for the image table pointer fetch block
`default_nettype none
module itpf_table_fetch_checker (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic external_c_out,
	input wire logic external_d_out,
	input wire logic external_s_n_out,
	input wire logic fetch_ready_out,
	input wire logic fetch_valid_out,
	input wire logic fetch_done_out,
	input wire logic status_initialization_out,
	input wire logic table_valid_out,
	input wire logic [31:0] repl_ptr_out,
	input wire logic [31:0] ebit_ptr_out,
	input wire logic repl_present_out,
	input wire logic ebit_present_out,
	input wire logic inject_strobe_in,
	input wire logic inject_strobe_out,
	input wire logic inject_pins_present_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	sequence lead_zeros; ##11 (external_c_out && !external_d_out); endsequence
	sequence read_ones; (external_c_out && external_d_out) ##2 (external_c_out && external_d_out); endsequence
	chk_idle_clk_low: assert property (external_s_n_out |-> !external_c_out) else $error("clock not idle low");
	chk_clk_half_rate: assert property ($rose(external_c_out) |=> $fell(external_c_out)) else $error("clock rate");
	chk_read_cmd: assert property ($fell(external_s_n_out) |-> lead_zeros ##2 read_ones) else $error("bad cmd");
	chk_repl_present: assert property (repl_present_out == (table_valid_out && repl_ptr_out != 32'h0))
		else $error("repl presence");
	chk_ebit_present: assert property (ebit_present_out == (table_valid_out && ebit_ptr_out != 32'h0))
		else $error("ebit presence");
	chk_inject_pass: assert property (!$past(srst_in) |->
		inject_strobe_out == ($past(inject_strobe_in) && inject_pins_present_out)) else $error("inject");
	chk_done_with_byte: assert property (fetch_done_out |-> fetch_valid_out) else $error("done alone");
	chk_ready_loaded: assert property (fetch_ready_out |-> table_valid_out && !status_initialization_out)
		else $error("ready early");
endmodule
bind itpf_table_fetch itpf_table_fetch_checker chk_i (.core_clk_in, .srst_in, .external_c_out, .external_d_out,
	.external_s_n_out, .fetch_ready_out, .fetch_valid_out, .fetch_done_out, .status_initialization_out,
	.table_valid_out, .repl_ptr_out, .ebit_ptr_out, .repl_present_out, .ebit_present_out, .inject_strobe_in,
	.inject_strobe_out, .inject_pins_present_out);
`default_nettype wire

// ### testbench/itpf_table_fetch_tb_top.sv
// Self-checking bench for the image table pointer fetch block
`default_nettype none
module itpf_table_fetch_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0, srst_in = 1'b1, fetch_req_in = 1'b0, inject_strobe_in = 1'b0, external_q_in;
	logic [31:0] tbladdr_in = 32'h10, fetch_addr_in = 32'h0, repl_ptr_out, ebit_ptr_out;
	logic [15:0] fetch_count_in = 16'h0;
	logic [39:0] inject_address_in = 40'h0, inject_address_out;
	logic [7:0] fetch_data_out;
	logic fetch_ready_out, fetch_valid_out, fetch_done_out, status_initialization_out, table_valid_out;
	logic repl_present_out, ebit_present_out, image_missing_out, inject_pins_present_out, inject_strobe_out;
	logic external_c_out, external_d_out, external_s_n_out;
	logic h_init, h_ready, h_tv, h_s_n, h_pins, h_strobe;
	int bad_count = 0, tests_run = 0;
	always #5 core_clk_in = ~core_clk_in;
	itpf_table_fetch dut (.core_clk_in, .srst_in, .tbladdr_in, .fetch_req_in, .fetch_addr_in, .fetch_count_in,
		.fetch_ready_out, .fetch_data_out, .fetch_valid_out, .fetch_done_out, .status_initialization_out,
		.table_valid_out, .repl_ptr_out, .ebit_ptr_out, .repl_present_out, .ebit_present_out, .image_missing_out,
		.inject_strobe_in, .inject_address_in, .inject_pins_present_out, .inject_strobe_out, .inject_address_out,
		.external_c_out, .external_d_out, .external_s_n_out, .external_q_in);
	itpf_flash_model flash (.c_in(external_c_out), .s_n_in(external_s_n_out), .d_in(external_d_out),
		.q_out(external_q_in));
	// Second copy stays in init and has no injection pins
	itpf_table_fetch #(.INJECT_ENABLE(1'b0), .SIM_HOLD(1'b1)) dut_hold (.core_clk_in, .srst_in, .tbladdr_in,
		.fetch_req_in, .fetch_addr_in, .fetch_count_in, .fetch_ready_out(h_ready), .fetch_data_out(),
		.fetch_valid_out(), .fetch_done_out(), .status_initialization_out(h_init), .table_valid_out(h_tv),
		.repl_ptr_out(), .ebit_ptr_out(), .repl_present_out(), .ebit_present_out(), .image_missing_out(),
		.inject_strobe_in, .inject_address_in, .inject_pins_present_out(h_pins), .inject_strobe_out(h_strobe),
		.inject_address_out(), .external_c_out(), .external_d_out(), .external_s_n_out(h_s_n), .external_q_in(1'b0));
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		if (bad_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task t_table;
		for (int i = 0; i < 3000 && fetch_ready_out !== 1'b1; i++) @(negedge core_clk_in);
		chk(fetch_ready_out, 1'b1);
		chk(repl_ptr_out, 32'h5a000040);
		chk(ebit_ptr_out, 32'h0);
		chk({repl_present_out, ebit_present_out, image_missing_out}, 3'b101);
		chk(status_initialization_out, 1'b0);
		chk({h_init, h_ready, h_tv, h_s_n}, 4'b1001);
	endtask
	task t_fetch;
		int k;
		k = 0;
		fetch_req_in = 1'b1;
		@(negedge core_clk_in);
		// Zero count must be dropped without returning any byte
		for (int i = 0; i < 90; i++) @(negedge core_clk_in) k += (fetch_valid_out !== 1'b0);
		chk(k, 0);
		fetch_count_in = 16'h3;
		fetch_addr_in = repl_ptr_out;
		@(negedge core_clk_in);
		fetch_req_in = 1'b0;
		for (int i = 0; i < 400 && k < 3; i++) @(negedge core_clk_in) if (fetch_valid_out === 1'b1) begin
			chk(fetch_data_out, (8'h40 + 8'(k)) ^ 8'h5a);
			chk(fetch_done_out, k == 2);
			k++;
		end
		chk(k, 3);
	endtask
	task t_inject;
		inject_strobe_in = 1'b1;
		inject_address_in = 40'h123456789a;
		@(negedge core_clk_in);
		chk({inject_pins_present_out, inject_strobe_out, inject_address_out}, {2'b11, 40'h123456789a});
		chk({h_pins, h_strobe}, 2'b00);
		inject_strobe_in = 1'b0;
	endtask
	task t_reset;
		srst_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		chk({status_initialization_out, fetch_ready_out, external_s_n_out, table_valid_out}, 4'b1010);
		srst_in = 1'b0;
		t_table();
	endtask
	initial begin
		repeat (8) @(negedge core_clk_in);
		srst_in = 1'b0;
		t_table();
		t_fetch();
		t_inject();
		t_reset();
		end_sim();
	end
	// Whole run needs about 600 cycles
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
